// >>> smc_cpu_model.sv
/* cpu core and debug host model that issue stop and debug commands.
   assumes the bench pulses its command inputs for one cycle. */
`timescale 1ns/10ps
`default_nettype none
module smc_cpu_model
  import smc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stopCmd,
  input wire smc_dbg_req_t dbgCmd,
  input wire smc_state_t stateOut,
  output logic stopExec,
  output smc_dbg_req_t dbgReq
);
  // a stop instruction only executes while the core runs
  always_ff @(posedge clk) begin
    if (!rst_n) stopExec <= 1'b0;
    else stopExec <= stopCmd && stateOut == SMC_RUN;
  end
  // debug host sends one-cycle command pulses, none in reset
  always_ff @(posedge clk) begin
    if (!rst_n) dbgReq <= '0;
    else dbgReq <= dbgCmd;
  end
endmodule
`default_nettype wire

// >>> smc_defines.svh
/*
 * constants for the stop mode controller: register offsets, field
 * positions, reset values and timing counts.
 * assumes inclusion by bare name from the controller, its checker and the bench.
 */
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH

// register offsets on the plain software port
`define SMC_ADDR_W 4
`define SMC_OFS_PMC1 4'h0
`define SMC_OFS_PMC2 4'h1
`define SMC_OFS_CLK 4'h2
`define SMC_OFS_STAT 4'h3
`define SMC_OFS_DBG 4'h4

// power_mgmt_control_one fields
`define SMC_P1_LOW_VOLTAGE_DETECT_ENABLE 0
`define SMC_P1_LVSE 1
`define SMC_P1_STPE 2
`define SMC_PMC1_RST 8'h03

// power_mgmt_control_two fields
`define SMC_P2_SEL 0
`define SMC_P2_ACK 1
`define SMC_P2_FLAG 2
`define SMC_PMC2_RST 8'h00

// clock_gen_control fields
`define SMC_CK_IRC 0
`define SMC_CK_IRS 1
`define SMC_CK_ERC 2
`define SMC_CK_ERS 3
`define SMC_CK_HFR 4
`define SMC_CK_ADA 5
`define SMC_CK_RTE 6
`define SMC_CK_OLD 7
`define SMC_CLK_RST 8'h00

// debug_status_control field
`define SMC_DBG_EN 0

// wake-up reset length in bus cycles (time in ns, count derived)
`define SMC_WAKE_NS 1000
`define SMC_CLK_NS 100
`define SMC_WAKE_CYC ((`SMC_WAKE_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)

`endif

// >>> smc_pkg.sv
/*
 * types for the stop mode controller.
 * assumes smc_defines.svh is on the include path.
 */
`default_nettype none
package smc_pkg;
  // stop controller states, gray coded along run, shallow, deep, wake
  typedef enum logic [1:0] {
    SMC_RUN = 2'b00,
    SMC_SHALLOW = 2'b01,
    SMC_DEEP = 2'b11,
    SMC_WAKE = 2'b10
  } smc_state_t;

  // keep-alive enables toward the power islands
  typedef struct packed {
    logic regulatorOn;
    logic debugClockOn;
    logic adcOn;
    logic clockGenRefOn;
    logic oscOn;
    logic rtcOn;
    logic periphClockOn;
    logic coreStandby;
  } smc_power_t;

  // debug port request toward the block
  typedef struct packed {
    logic background;
    logic memStatus;
    logic other;
  } smc_dbg_req_t;
endpackage
`default_nettype wire

// >>> smc_stop_mode_controller.sv
/*
 * stop mode controller: chooses shallow or deep stop on a stop
 * instruction, gates power islands and clocks, latches pins in deep
 * stop and drives the wake reset and recovery flag.
 * assumes one 10 MHz bus clock, a synchronous active-low reset, a cpu
 * that pulses stopExec on a stop instruction, and that rst_n models a
 * power-on style reset of this block.
 */
`timescale 1ns/10ps
`default_nettype none
`include "smc_defines.svh"

module smc_stop_mode_controller
  import smc_pkg::*;
#(
  parameter int WAKE_CYC = `SMC_WAKE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`SMC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic stopExec,
  input wire logic wakeIrq,
  input wire logic irqPinRaw,
  input wire logic rtcWake,
  input wire smc_dbg_req_t dbgReq,
  output logic dbgAccept,
  output logic dbgStopError,
  output logic backgroundActive,
  output logic illegalOpReset,
  output logic wakeReset,
  output logic lowTripSelect,
  output logic pinLatchClosed,
  output smc_power_t power,
  output smc_state_t stateOut
);

  // ************************************************************
  // state and registers
  // ************************************************************
  smc_state_t state;
  smc_state_t next_state;
  logic [7:0] pmc1;
  logic [7:0] clkCfg;
  logic debugEnable;
  logic deepSelect;
  logic recoveryFlag;
  logic [2:0] irqSync;
  logic [$clog2(WAKE_CYC+1)-1:0] wakeCnt;
  logic wakeDone;
  logic deepReq;
  logic stopAllowed;
  logic ackWrite;
  logic irqLow;
  logic deepWake;
  logic anyStop;
  smc_power_t next_power;
  // snapshot of the enables seen at stop entry
  logic lvdKeep;
  logic dbgKeep;

  function automatic logic isWrite(input logic [`SMC_ADDR_W-1:0] a,
                                   input logic [`SMC_ADDR_W-1:0] o);
    isWrite = regWrite && (a == o);
  endfunction

  assign stopAllowed = pmc1[`SMC_P1_STPE];
  // deep only when selected and neither debug nor full stop detector
  assign deepReq = deepSelect && !debugEnable &&
                   !(pmc1[`SMC_P1_LOW_VOLTAGE_DETECT_ENABLE] && pmc1[`SMC_P1_LVSE]);
  assign ackWrite = isWrite(regAddr, `SMC_OFS_PMC2) &&
                    regWdata[`SMC_P2_ACK];
  assign irqLow = clkCfg[`SMC_CK_OLD] && !irqSync[2] && !irqSync[1];
  assign deepWake = irqLow || (rtcWake && clkCfg[`SMC_CK_RTE]);
  assign anyStop = (state == SMC_SHALLOW) || (state == SMC_DEEP);
  assign wakeDone = (wakeCnt == '0);

  // ************************************************************
  // irq pin synchroniser, three stages
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqSync <= 3'h7;
    end else begin
      irqSync <= {irqSync[1:0], irqPinRaw};
    end
  end

  // ************************************************************
  // software registers
  // ************************************************************
  // control one and clock config; deep wake resets them like power-on
  always_ff @(posedge clk) begin
    if (!rst_n || state == SMC_WAKE) begin
      pmc1 <= `SMC_PMC1_RST;
      clkCfg <= `SMC_CLK_RST;
      deepSelect <= 1'b0;
    end else if (state == SMC_RUN) begin
      if (isWrite(regAddr, `SMC_OFS_PMC1)) begin
        pmc1 <= regWdata;
      end
      if (isWrite(regAddr, `SMC_OFS_CLK)) begin
        clkCfg <= regWdata;
      end
      if (isWrite(regAddr, `SMC_OFS_PMC2)) begin
        deepSelect <= regWdata[`SMC_P2_SEL];
      end
    end
  end

  // debug enable lives in the debug status register; wake clears it
  always_ff @(posedge clk) begin
    if (!rst_n || state == SMC_WAKE) begin
      debugEnable <= 1'b0;
    end else if (isWrite(regAddr, `SMC_OFS_DBG)) begin
      debugEnable <= regWdata[`SMC_DBG_EN];
    end
  end

  // recovery flag: wake sets it, ack 1 clears it, set wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recoveryFlag <= 1'b0;
    end else if (state == SMC_WAKE && wakeDone) begin
      recoveryFlag <= 1'b1;
    end else if (ackWrite) begin
      recoveryFlag <= 1'b0;
    end
  end

  // pin latches close on deep entry, open only on reset or on an acknowledge outside wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinLatchClosed <= 1'b0;
    end else if (state == SMC_RUN && stopExec && stopAllowed && deepReq) begin
      pinLatchClosed <= 1'b1;
    end else if (ackWrite && !(state == SMC_WAKE)) begin
      pinLatchClosed <= 1'b0;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      if (regAddr == `SMC_OFS_PMC1) begin
        regRdata <= pmc1;
      end else if (regAddr == `SMC_OFS_PMC2) begin
        regRdata <= {5'h00, recoveryFlag, 1'b0, deepSelect};
      end else if (regAddr == `SMC_OFS_CLK) begin
        regRdata <= clkCfg;
      end else if (regAddr == `SMC_OFS_STAT) begin
        regRdata <= {4'h0, pinLatchClosed, backgroundActive, state};
      end else if (regAddr == `SMC_OFS_DBG) begin
        regRdata <= {7'h00, debugEnable};
      end else begin
        regRdata <= 8'h00;
      end
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ************************************************************
  // stop sequencing
  // ************************************************************
  always_comb begin
    next_state = state;
    case (state)
      SMC_RUN: begin
        if (stopExec && stopAllowed) begin
          next_state = deepReq ? SMC_DEEP : SMC_SHALLOW;
        end
      end
      SMC_SHALLOW: begin
        if (wakeIrq || (dbgReq.background && dbgKeep)) begin
          next_state = SMC_RUN;
        end
      end
      SMC_DEEP: begin
        if (deepWake) begin
          next_state = SMC_WAKE;
        end
      end
      SMC_WAKE: begin
        if (wakeDone) begin
          next_state = SMC_RUN;
        end
      end
      default: begin
        next_state = SMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= SMC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // wake reset length counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wakeCnt <= '0;
    end else if (state == SMC_DEEP && deepWake) begin
      wakeCnt <= ($clog2(WAKE_CYC+1))'(WAKE_CYC - 1);
    end else if (!wakeDone) begin
      wakeCnt <= wakeCnt - 1'b1;
    end
  end

  // enables snapshotted on the stop instruction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvdKeep <= 1'b0;
      dbgKeep <= 1'b0;
    end else if (state == SMC_RUN && stopExec && stopAllowed) begin
      lvdKeep <= pmc1[`SMC_P1_LOW_VOLTAGE_DETECT_ENABLE] && pmc1[`SMC_P1_LVSE];
      dbgKeep <= debugEnable;
    end
  end

  // ************************************************************
  // cpu, reset and debug outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      illegalOpReset <= 1'b0;
      wakeReset <= 1'b0;
      lowTripSelect <= 1'b1;
      stateOut <= SMC_RUN;
    end else begin
      illegalOpReset <= (state == SMC_RUN) && stopExec && !stopAllowed;
      wakeReset <= (next_state == SMC_WAKE);
      lowTripSelect <= (next_state == SMC_WAKE) ? 1'b1 : lowTripSelect;
      stateOut <= next_state;
    end
  end

  // background mode entry from stop and debug command answers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      backgroundActive <= 1'b0;
      dbgAccept <= 1'b0;
      dbgStopError <= 1'b0;
    end else begin
      if (state == SMC_SHALLOW && dbgReq.background && dbgKeep) begin
        backgroundActive <= 1'b1;
      end else if (state == SMC_WAKE) begin
        backgroundActive <= 1'b0;
      end else if (dbgReq.other && state == SMC_RUN && !debugEnable) begin
        backgroundActive <= 1'b0;
      end
      dbgStopError <= anyStop && dbgReq.memStatus;
      dbgAccept <= backgroundActive ?
                   (dbgReq.background || dbgReq.memStatus || dbgReq.other) :
                   (!anyStop && (dbgReq.background || dbgReq.memStatus ||
                   dbgReq.other));
    end
  end

  // ************************************************************
  // power island enables
  // ************************************************************
  always_comb begin
    next_power = '{default: 1'b1};
    next_power.coreStandby = 1'b0;
    if (next_state == SMC_SHALLOW) begin
      next_power.periphClockOn = 1'b0;
      next_power.coreStandby = 1'b1;
      next_power.debugClockOn = dbgKeep || (state == SMC_RUN && debugEnable);
      next_power.regulatorOn = lvdKeep || dbgKeep ||
        (state == SMC_RUN && (debugEnable ||
        (pmc1[`SMC_P1_LOW_VOLTAGE_DETECT_ENABLE] && pmc1[`SMC_P1_LVSE])));
      next_power.adcOn = clkCfg[`SMC_CK_ADA] && (lvdKeep ||
        (state == SMC_RUN && pmc1[`SMC_P1_LOW_VOLTAGE_DETECT_ENABLE] &&
        pmc1[`SMC_P1_LVSE]));
      next_power.clockGenRefOn = clkCfg[`SMC_CK_IRC] &&
                                 clkCfg[`SMC_CK_IRS];
      next_power.oscOn = clkCfg[`SMC_CK_ERC] && clkCfg[`SMC_CK_ERS] &&
        (!clkCfg[`SMC_CK_HFR] || pmc1[`SMC_P1_LOW_VOLTAGE_DETECT_ENABLE]);
      next_power.rtcOn = clkCfg[`SMC_CK_RTE];
    end else if (next_state == SMC_DEEP) begin
      next_power = '{default: 1'b0};
      next_power.rtcOn = clkCfg[`SMC_CK_RTE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power <= '{default: 1'b1};
    end else begin
      power <= next_power;
    end
  end

endmodule
`default_nettype wire

// >>> smc_stop_mode_controller_asserts.sv
/* port checker for the stop mode controller.
   assumes it is bound into smc_stop_mode_controller. */
`timescale 1ns/10ps
`default_nettype none
`include "smc_defines.svh"
module smc_stop_mode_controller_asserts
  import smc_pkg::*;
#(parameter int WAKE_CYC = `SMC_WAKE_CYC) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`SMC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic stopExec,
  input wire smc_dbg_req_t dbgReq,
  input wire logic dbgAccept,
  input wire logic dbgStopError,
  input wire logic backgroundActive,
  input wire logic illegalOpReset,
  input wire logic wakeReset,
  input wire logic lowTripSelect,
  input wire logic pinLatchClosed,
  input wire smc_power_t power,
  input wire smc_state_t stateOut
);
  logic [7:0] wakeCnt;
  logic stopped;
  logic ackWr;
  // counts consecutive wake reset cycles
  always_ff @(posedge clk) begin
    if (!rst_n) wakeCnt <= 8'h00;
    else wakeCnt <= wakeReset ? wakeCnt + 8'h01 : 8'h00;
  end
  // any stop state and a software acknowledge write
  assign stopped = stateOut == SMC_SHALLOW || stateOut == SMC_DEEP;
  assign ackWr = regWrite && regAddr == `SMC_OFS_PMC2 && regWdata[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_stop_periph_off: assert property (
    stopped |-> !power.periphClockOn)
    else $error("peripheral clock alive in stop");
  a_deep_islands_off: assert property (stateOut == SMC_DEEP |->
    pinLatchClosed && !power.regulatorOn && !power.adcOn && !power.oscOn)
    else $error("deep stop islands or latches wrong");
  a_illegal_cause: assert property ($rose(illegalOpReset) |->
    $past(stopExec) && $past(stateOut) == SMC_RUN)
    else $error("illegal reset without stop");
  a_wake_from_deep: assert property ($rose(wakeReset) |->
    $past(stateOut) == SMC_DEEP)
    else $error("wake reset not from deep stop");
  a_wake_length: assert property ($fell(wakeReset) |->
    wakeCnt == 8'(WAKE_CYC))
    else $error("wake reset length wrong");
  a_wake_to_run: assert property ($fell(wakeReset) |->
    stateOut == SMC_RUN && pinLatchClosed && lowTripSelect)
    else $error("bad state after wake");
  a_latch_held: assert property (
    $fell(pinLatchClosed) && $past(rst_n) |-> $past(ackWr))
    else $error("latches opened without ack");
  a_ack_opens: assert property (stateOut == SMC_RUN && ackWr |=>
    !pinLatchClosed)
    else $error("ack did not open latches");
  a_dbg_regulator: assert property (stateOut == SMC_SHALLOW &&
    power.debugClockOn |-> power.regulatorOn)
    else $error("regulator off with debug on");
  a_memstat_err: assert property (stateOut == SMC_SHALLOW &&
    dbgReq.memStatus |=> dbgStopError && !dbgAccept)
    else $error("status command not refused");
  a_bg_wake: assert property (stateOut == SMC_SHALLOW &&
    power.debugClockOn && dbgReq.background |=> backgroundActive)
    else $error("background did not wake");
  a_bg_accept: assert property (backgroundActive && dbgReq.other
    |=> dbgAccept)
    else $error("command refused in background");
endmodule
bind smc_stop_mode_controller smc_stop_mode_controller_asserts
  #(.WAKE_CYC(WAKE_CYC)) smc_stop_mode_controller_asserts_inst (
  .clk, .rst_n, .regAddr, .regWdata, .regWrite, .stopExec, .dbgReq,
  .dbgAccept, .dbgStopError, .backgroundActive, .illegalOpReset,
  .wakeReset, .lowTripSelect, .pinLatchClosed, .power, .stateOut);
`default_nettype wire

// >>> smc_stop_mode_controller_tb.sv
/* self-checking bench for the stop mode controller.
   assumes the package, defines header, model and checker compiled. */
`timescale 1ns/10ps
`default_nettype none
`include "smc_defines.svh"
module smc_stop_mode_controller_tb
  import smc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [`SMC_ADDR_W-1:0] regAddr = '0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic regWrite = 1'b0, regRead = 1'b0, stopCmd = 1'b0, stopExec;
  logic wakeIrq = 1'b0, irqPinRaw = 1'b1, rtcWake = 1'b0;
  logic dbgAccept, dbgStopError, backgroundActive, illegalOpReset;
  logic wakeReset, lowTripSelect, pinLatchClosed;
  smc_dbg_req_t dbgCmd = '0, dbgReq;
  smc_power_t power;
  smc_state_t stateOut;
  int failures = 0, testsRun = 0;
  smc_stop_mode_controller #(.WAKE_CYC(2)) smc_stop_mode_controller_inst (
    .clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .stopExec, .wakeIrq, .irqPinRaw, .rtcWake, .dbgReq, .dbgAccept,
    .dbgStopError, .backgroundActive, .illegalOpReset, .wakeReset,
    .lowTripSelect, .pinLatchClosed, .power, .stateOut);
  smc_cpu_model smc_cpu_model_inst (
    .clk, .rst_n, .stopCmd, .dbgCmd, .stateOut, .stopExec, .dbgReq);
  // 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    testsRun++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  // one command through the model, checked after the design answers
  task automatic cmd(input logic s, input smc_dbg_req_t d);
    @(posedge clk);
    stopCmd <= s;
    dbgCmd <= d;
    @(posedge clk);
    stopCmd <= 1'b0;
    dbgCmd <= '0;
    @(posedge clk);
    #1;
  endtask
  task automatic setup(input logic [7:0] p1, p2, ck, dbg);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    wr(`SMC_OFS_PMC1, p1);
    wr(`SMC_OFS_PMC2, p2);
    wr(`SMC_OFS_CLK, ck);
    wr(`SMC_OFS_DBG, dbg);
  endtask
  task automatic t_reset();
    setup(8'h03, 8'h00, 8'h00, 8'h00);
    rd(`SMC_OFS_PMC1, 8'h03);
    rd(4'hf, 8'h00);
    chk(power, 8'hfe);
    chk({6'h00, lowTripSelect, pinLatchClosed}, 8'h02);
    cmd(1'b1, 3'b000);
    chk({5'h00, illegalOpReset, stateOut}, 8'h04);
    $display("done reset and illegal stop");
  endtask
  task automatic t_debug();
    setup(8'h05, 8'h01, 8'h00, 8'h01);
    cmd(1'b1, 3'b000);
    chk({6'h00, stateOut}, 8'h01);
    chk({4'h0, power[7:6], power[1:0]}, 8'h0d);
    cmd(1'b0, 3'b010);
    chk({7'h00, dbgStopError}, 8'h01);
    cmd(1'b0, 3'b100);
    chk({7'h00, backgroundActive}, 8'h01);
    cmd(1'b0, 3'b001);
    chk({7'h00, dbgAccept}, 8'h01);
    $display("done debug stop");
  endtask
  task automatic t_shallow(input logic [7:0] p1, p2, ck, ep);
    setup(p1, p2, ck, 8'h00);
    cmd(1'b1, 3'b000);
    chk({6'h00, stateOut}, 8'h01);
    chk(power, ep);
    // a wake interrupt ends shallow stop and restores the islands
    @(posedge clk);
    wakeIrq <= 1'b1;
    @(posedge clk);
    wakeIrq <= 1'b0;
    #1 chk({6'h00, stateOut}, 8'h00);
    chk(power, 8'hfe);
    $display("done shallow stop");
  endtask
  task automatic t_deep(input logic [7:0] ck, input logic useRtc);
    int n;
    setup(8'h04, 8'h01, ck, 8'h00);
    cmd(1'b1, 3'b000);
    chk({6'h00, stateOut}, 8'h03);
    chk({7'h00, pinLatchClosed}, 8'h01);
    chk({1'b0, power[7:1]}, {6'h00, useRtc, 1'b0});
    @(posedge clk);
    rtcWake <= useRtc;
    irqPinRaw <= useRtc;
    n = 0;
    while (wakeReset !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    rtcWake <= 1'b0;
    irqPinRaw <= 1'b1;
    chk({7'h00, wakeReset}, 8'h01);
    n = 0;
    while (wakeReset === 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'h02);
    chk({5'h00, lowTripSelect, pinLatchClosed, stateOut == SMC_RUN},
      8'h07);
    rd(`SMC_OFS_PMC2, 8'h04);
    rd(`SMC_OFS_PMC1, 8'h03);
    wr(`SMC_OFS_PMC2, 8'h02);
    #1 chk({7'h00, pinLatchClosed}, 8'h00);
    rd(`SMC_OFS_PMC2, 8'h00);
    $display("done deep stop");
  endtask
  // watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test();
  end
  // main sequence
  initial begin
    t_reset();
    t_debug();
    t_shallow(8'h07, 8'h01, 8'h7f, 8'hbd);
    t_shallow(8'h04, 8'h00, 8'h3f, 8'h11);
    t_deep(8'h40, 1'b1);
    t_deep(8'h80, 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
